// ### core/mdsr_defs.vh
`ifndef MDSR_DEFS_VH
`define MDSR_DEFS_VH
// ==================================================
// register addresses (5-bit clause-22 register field)
`define MDSR_ADDR_STATUS   5'h01
`define MDSR_ADDR_ID_HIGH  5'h02
`define MDSR_ADDR_ID_LOW   5'h03
`define MDSR_ADDR_ADVERT   5'h04
`define MDSR_ADDR_DEV_ID   5'h1f
// ==================================================
// basic status bit positions
`define MDSR_BIT_EXT_STATUS  8
`define MDSR_BIT_PRE_SKIP    6
`define MDSR_BIT_AN_DONE     5
`define MDSR_BIT_REMOTE_FAULT_FLAG      4
`define MDSR_BIT_AN_CAPABLE  3
`define MDSR_BIT_LINK_UP     2
`define MDSR_BIT_EXT_REGS    0
// ==================================================
// advertisement layout and strap reset values
`define MDSR_ADV_WMASK       16'hbfff
`define MDSR_ADV_RST_NONE    16'h0000
`define MDSR_ADV_RST_SG_LO   16'h9001
`define MDSR_ADV_RST_SG_1G   16'h9801
`define MDSR_ADV_RST_BASEX   16'h0020
`define MDSR_ADV_BIT_R       10
`define MDSR_ID_ZERO         16'h0000
// ==================================================
// frame fields
`define MDSR_ST_BITS   2'b01
`define MDSR_OP_WRITE  2'b01
`define MDSR_OP_READ   2'b10
`define MDSR_TA_BITS   2'b10
`define MDSR_PRE_COUNT 6'd32
`endif

// ### core/mdsr_regs.v
`timescale 1ns/100ps
`include "mdsr_defs.vh"
`default_nettype none
module mdsr_regs #(
   parameter [4:0]  PHY_ADDR = 5'h00,   // station address
   parameter [15:0] DEV_ID   = 16'h1234 // arbitrary value
) (
   input  wire        clk_sys,           // system clock, 50 MHz
   input  wire        reset,             // async reset, active high
   input  wire        mdc,               // management clock pin
   input  wire        mdio_in,           // mdio pin level
   output reg         mdio_out,          // mdio drive value
   output reg         mdio_oe,           // mdio drive enable
   input  wire        strap_col,         // collision strap
   input  wire        strap_rx_dv,       // receive-valid strap
   input  wire [1:0]  strap_rxd,         // receive data straps
   input  wire        strap_second_general_output_strap,        // second general output strap
   input  wire        loss_of_signal_input, // loss-of-signal pin
   input  wire        cdr_lock_lost,     // clock recovery lost lock
   input  wire        pcs_link_up,       // pcs link-up state
   input  wire        autoneg_done,      // negotiation complete
   input  wire        sgmii_mode,        // 1 sgmii, 0 1000base-x
   input  wire [15:0] partner_ability_reg, // received config word
   output reg  [15:0] tx_config_word,    // config word to send
   output reg         remote_fault_flag, // interrupt mirror copy
   output reg         link_up_flag,      // interrupt mirror copy
   output reg         sgmii_adv_mode     // advert holds sgmii layout
);
   // ==================================================
   // pin synchronisers
   wire mdc_s;
   wire mdio_s;
   wire los_s;

   mdsr_sync3 #(.RESET_VAL(1'b0)) u_sync_mdc (
      .clk_sys (clk_sys),
      .reset   (reset),
      .din     (mdc),
      .dout    (mdc_s)
   );
   mdsr_sync3 #(.RESET_VAL(1'b1)) u_sync_mdio (
      .clk_sys (clk_sys),
      .reset   (reset),
      .din     (mdio_in),
      .dout    (mdio_s)
   );
   mdsr_sync3 #(.RESET_VAL(1'b0)) u_sync_los (
      .clk_sys (clk_sys),
      .reset   (reset),
      .din     (loss_of_signal_input),
      .dout    (los_s)
   );

   // ==================================================
   // edge detection of the filtered management clock
   reg  mdc_d_reg;
   wire mdc_rise = mdc_s & ~mdc_d_reg;
   wire mdc_fall = ~mdc_s & mdc_d_reg;

   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         mdc_d_reg <= 1'b0;
      end else begin
         mdc_d_reg <= mdc_s;
      end
   end

   // ==================================================
   // strap capture one cycle after reset release
   reg        strap_done_reg;
   reg [15:0] adv_strap;

   // strap decode into the advertisement reset pattern
   always @* begin
      if (strap_col) begin
         if (strap_second_general_output_strap) begin
            adv_strap = `MDSR_ADV_RST_BASEX;
         end else begin
            adv_strap = `MDSR_ADV_RST_SG_1G;
         end
      end else if (!strap_rx_dv) begin
         adv_strap = `MDSR_ADV_RST_NONE;
      end else if (!strap_rxd[1]) begin
         adv_strap = `MDSR_ADV_RST_SG_LO;
         adv_strap[`MDSR_ADV_BIT_R] = strap_rxd[0];
      end else if (strap_second_general_output_strap) begin
         adv_strap = `MDSR_ADV_RST_BASEX;
      end else begin
         adv_strap = `MDSR_ADV_RST_SG_1G;
      end
   end

   // ==================================================
   // frame receiver state machine
   localparam [2:0] ST_IDLE = 3'd0;
   localparam [2:0] ST_HEAD = 3'd1;
   localparam [2:0] ST_TA   = 3'd2;
   localparam [2:0] ST_DATA = 3'd3;
   localparam [2:0] ST_WAIT = 3'd4;

   reg [2:0]  state_reg;
   reg [4:0]  cnt_reg;
   reg [13:0] head_reg;     // st, op, phy address, register address
   reg [15:0] shift_reg;
   reg        rd_reg;
   reg        mine_reg;
   reg        rd_pulse_reg; // one-cycle read strobe
   reg        wr_pulse_reg; // one-cycle write strobe
   reg [4:0]  ra_reg;
   reg [15:0] wdata_reg;
   reg [15:0] adv_reg;
   reg [15:0] rdata;

   wire [13:0] head_nx = {head_reg[12:0], mdio_s};

   // read data multiplexer
   always @* begin
      rdata = 16'h0000;
      case (ra_reg)
         `MDSR_ADDR_STATUS: begin
            rdata[`MDSR_BIT_EXT_STATUS] = 1'b1;
            rdata[`MDSR_BIT_PRE_SKIP]   = 1'b1;
            rdata[`MDSR_BIT_AN_DONE]    = autoneg_done;
            rdata[`MDSR_BIT_REMOTE_FAULT_FLAG]     = remote_fault_flag;
            rdata[`MDSR_BIT_AN_CAPABLE] = 1'b1;
            rdata[`MDSR_BIT_LINK_UP]    = link_up_flag;
            rdata[`MDSR_BIT_EXT_REGS]   = 1'b1;
         end
         `MDSR_ADDR_ID_HIGH: rdata = `MDSR_ID_ZERO;
         `MDSR_ADDR_ID_LOW:  rdata = `MDSR_ID_ZERO;
         `MDSR_ADDR_ADVERT:  rdata = adv_reg & `MDSR_ADV_WMASK;
         `MDSR_ADDR_DEV_ID:  rdata = DEV_ID;
         default:            rdata = 16'h0000;
      endcase
   end

   // sampling on mdc rise, driving on mdc fall; no preamble needed
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         state_reg    <= ST_IDLE;
         cnt_reg      <= 5'd0;
         head_reg     <= 14'h0000;
         shift_reg    <= 16'h0000;
         rd_reg       <= 1'b0;
         mine_reg     <= 1'b0;
         rd_pulse_reg <= 1'b0;
         wr_pulse_reg <= 1'b0;
         ra_reg       <= 5'd0;
         wdata_reg    <= 16'h0000;
         mdio_out     <= 1'b1;
         mdio_oe      <= 1'b0;
      end else begin
         rd_pulse_reg <= 1'b0;
         wr_pulse_reg <= 1'b0;
         case (state_reg)
            ST_IDLE: begin
               // a zero on an idle line starts a frame
               if (mdc_rise && !mdio_s) begin
                  head_reg  <= 14'h0000;
                  cnt_reg   <= 5'd1;
                  state_reg <= ST_HEAD;
               end
            end
            ST_HEAD: begin
               if (mdc_rise) begin
                  head_reg <= head_nx;
                  cnt_reg  <= cnt_reg + 5'd1;
                  if (cnt_reg == 5'd13) begin
                     ra_reg   <= head_nx[4:0];
                     rd_reg   <= head_nx[11:10] == `MDSR_OP_READ;
                     mine_reg <= head_nx[9:5] == PHY_ADDR;
                     if (head_nx[13:12] != `MDSR_ST_BITS ||
                         (head_nx[11:10] != `MDSR_OP_READ &&
                          head_nx[11:10] != `MDSR_OP_WRITE)) begin
                        state_reg <= ST_WAIT;   // bad frame, resync
                     end else begin
                        cnt_reg   <= 5'd0;
                        state_reg <= ST_TA;
                     end
                  end
               end
            end
            ST_TA: begin
               // read: release on first ta bit, drive zero on second
               if (mdc_rise) begin
                  cnt_reg <= cnt_reg + 5'd1;
                  if (cnt_reg == 5'd0 && rd_reg && mine_reg) begin
                     shift_reg    <= rdata;
                     rd_pulse_reg <= 1'b1;
                  end
                  if (cnt_reg == 5'd1) begin
                     cnt_reg   <= 5'd0;
                     state_reg <= ST_DATA;
                  end
               end
               if (mdc_fall && cnt_reg == 5'd1 && rd_reg && mine_reg) begin
                  mdio_oe  <= 1'b1;
                  mdio_out <= 1'b0;
               end
            end
            ST_DATA: begin
               if (rd_reg) begin
                  if (mdc_fall && mine_reg) begin
                     mdio_out  <= shift_reg[15];
                     shift_reg <= {shift_reg[14:0], 1'b0};
                  end
                  if (mdc_rise) begin
                     cnt_reg <= cnt_reg + 5'd1;
                     if (cnt_reg == 5'd15) begin
                        state_reg <= ST_WAIT;
                     end
                  end
               end else if (mdc_rise) begin
                  wdata_reg <= {wdata_reg[14:0], mdio_s};
                  cnt_reg   <= cnt_reg + 5'd1;
                  if (cnt_reg == 5'd15) begin
                     wr_pulse_reg <= mine_reg;
                     state_reg    <= ST_IDLE;
                  end
               end
            end
            ST_WAIT: begin
               // release the line after the last bit's falling edge
               if (mdc_fall) begin
                  mdio_oe   <= 1'b0;
                  mdio_out  <= 1'b1;
                  state_reg <= ST_IDLE;
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // ==================================================
   // latched status flags
   wire fault_now = sgmii_mode ? (los_s | cdr_lock_lost)
                               : (partner_ability_reg[13:12] != 2'b00);
   wire stat_read = rd_pulse_reg && ra_reg == `MDSR_ADDR_STATUS;

   // fault sets win over the read clear; link drop wins over read set
   // the flag registers are the ports, so the interrupt copy never lags
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         remote_fault_flag <= 1'b0;
         link_up_flag      <= 1'b0;
      end else begin
         if (fault_now) begin
            remote_fault_flag <= 1'b1;
         end else if (stat_read) begin
            remote_fault_flag <= 1'b0;
         end
         if (!pcs_link_up) begin
            link_up_flag <= 1'b0;
         end else if (stat_read) begin
            link_up_flag <= 1'b1;
         end
      end
   end

   // ==================================================
   // advertisement register, loaded from straps after reset release
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         strap_done_reg <= 1'b0;
         adv_reg        <= 16'h0000;
         tx_config_word <= 16'h0000;
         sgmii_adv_mode <= 1'b0;
      end else begin
         if (!strap_done_reg) begin
            strap_done_reg <= 1'b1;
            adv_reg        <= adv_strap;
         end else if (wr_pulse_reg && ra_reg == `MDSR_ADDR_ADVERT) begin
            adv_reg <= wdata_reg & `MDSR_ADV_WMASK;
         end
         tx_config_word <= adv_reg & `MDSR_ADV_WMASK;
         sgmii_adv_mode <= adv_reg[0];
      end
   end
endmodule
`default_nettype wire

// ### core/mdsr_sync3.v
`timescale 1ns/100ps
`default_nettype none
// ==================================================
// three-stage synchroniser; the level changes once stages two and three agree
module mdsr_sync3 #(
   parameter RESET_VAL = 1'b0
) (
   input  wire clk_sys,   // system clock
   input  wire reset,     // async reset, active high
   input  wire din,       // asynchronous input
   output reg  dout       // filtered level
);
   reg s1_reg;
   reg s2_reg;
   reg s3_reg;

   // stage chain; s1 feeds only s2
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         s1_reg <= RESET_VAL;
         s2_reg <= RESET_VAL;
         s3_reg <= RESET_VAL;
         dout   <= RESET_VAL;
      end else begin
         s1_reg <= din;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         if (s2_reg == s3_reg) begin
            dout <= s3_reg;
         end
      end
   end
endmodule
`default_nettype wire

// ### verif/mdsr_mdio_master.sv
`timescale 1ns/100ps
`default_nettype none
// ==================================================
// station manager model; mdc stands still between frames
module mdsr_mdio_master #(
   parameter int H = 8
) (
   input  wire logic clk_sys,  // system clock
   output var  logic mdc,      // management clock
   output wire logic mdio_in,  // resolved line level
   input  wire logic mdio_out, // device drive value
   input  wire logic mdio_oe   // device drive enable
);
   logic m_oe = 1'b0;
   logic m_val = 1'b1;
   initial mdc = 1'b0;
   // pull-up on the line, so a released line reads 1
   assign mdio_in = mdio_oe ? mdio_out : (m_oe ? m_val : 1'b1);
   // set up while mdc is low, sample just before the rise
   task automatic bit_io(input logic oe, input logic b, output logic s);
      mdc <= 1'b0;
      m_oe <= oe;
      m_val <= b;
      repeat (H) @(posedge clk_sys);
      s = mdio_in;
      mdc <= 1'b1;
      repeat (H) @(posedge clk_sys);
   endtask
   // one frame, optional preamble; the last fall lets the device release
   task automatic frame(input logic pre, input logic [1:0] op,
      input logic [4:0] phy, input logic [4:0] ra, input logic [15:0] wd,
      output logic [15:0] rd);
      logic [13:0] hdr;
      logic        s;
      hdr = {2'b01, op, phy, ra};
      for (int i = 0; i < 32; i++)
         if (pre) bit_io(1'b1, 1'b1, s);
      for (int i = 13; i >= 0; i--)
         bit_io(1'b1, hdr[i], s);
      bit_io(op == 2'b01, 1'b1, s);
      bit_io(op == 2'b01, 1'b0, s);
      for (int i = 15; i >= 0; i--) begin
         bit_io(op == 2'b01, wd[i], s);
         rd[i] = s;
      end
      bit_io(1'b0, 1'b1, s);
   endtask
endmodule
`default_nettype wire

// ### verif/mdsr_regs_asserts.sv
`timescale 1ns/100ps
`default_nettype none
// ==================================================
// port checks of the latched flags, the advertisement mirror and the read turnaround
module mdsr_regs_asserts (
   input wire logic        clk_sys,              // system clock
   input wire logic        reset,                // async reset
   input wire logic        mdio_out,             // mdio drive value
   input wire logic        mdio_oe,              // mdio drive enable
   input wire logic        loss_of_signal_input, // loss pin
   input wire logic        cdr_lock_lost,        // lock lost
   input wire logic        pcs_link_up,          // pcs link up
   input wire logic        sgmii_mode,           // fault source select
   input wire logic [15:0] partner_ability_reg,  // received word
   input wire logic [15:0] tx_config_word,       // sent word
   input wire logic        remote_fault_flag,    // latched high
   input wire logic        link_up_flag,         // latched low
   input wire logic        sgmii_adv_mode        // advert layout
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);
   // a read strobe is always followed by the answer on the line
   sequence s_read_answer;
      ##[1:40] $rose(mdio_oe);
   endsequence
   // turnaround zero, then the drive enable is held for the next 8 cycles
   sequence s_turnaround;
      !mdio_out ##1 mdio_oe [*8];
   endsequence
   // pin is synchronised first, hence the slack
   a_rf_los_set: assert property (
      (sgmii_mode && loss_of_signal_input) [*4] |-> ##[0:6] remote_fault_flag)
      else $error("loss of signal did not latch the fault");
   a_rf_cdr_set: assert property (
      sgmii_mode && cdr_lock_lost |-> ##[1:2] remote_fault_flag)
      else $error("lost lock did not latch the fault");
   a_rf_word_set: assert property (
      !sgmii_mode && partner_ability_reg[13:12] != 2'b00
      |-> ##[1:2] remote_fault_flag)
      else $error("partner fault field did not latch the fault");
   a_rf_read_clear: assert property (
      $fell(remote_fault_flag) |-> !$past(cdr_lock_lost) ##0 s_read_answer)
      else $error("fault flag cleared outside a read");
   a_link_drop: assert property (
      !pcs_link_up |=> !link_up_flag)
      else $error("link flag not latched low");
   a_link_read_set: assert property (
      $rose(link_up_flag) |-> $past(pcs_link_up) ##0 s_read_answer)
      else $error("link flag set outside a read with link up");
   a_tx_bit14: assert property (
      tx_config_word[14] == 1'b0)
      else $error("config word bit 14 set");
   a_mode_mirror: assert property (
      $stable(tx_config_word) [*2] |=> sgmii_adv_mode == tx_config_word[0])
      else $error("layout flag differs from config word");
   a_ta_zero: assert property (
      $rose(mdio_oe) |-> s_turnaround)
      else $error("turnaround not driven low");
endmodule
bind mdsr_regs mdsr_regs_asserts u_chk (.clk_sys, .reset, .mdio_out,
   .mdio_oe, .loss_of_signal_input, .cdr_lock_lost, .pcs_link_up,
   .sgmii_mode, .partner_ability_reg, .tx_config_word, .remote_fault_flag,
   .link_up_flag, .sgmii_adv_mode);
`default_nettype wire

// ### verif/mdsr_regs_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "mdsr_defs.vh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
   mismatches++; $display("Error %s exp %h got %h", n, e, g); end end
// ==================================================
// register bank bench
module mdsr_regs_tb;
   localparam logic [15:0] DEVID = 16'h5a3c; // arbitrary value
   // straps {col, rx_dv, rxd1, rxd0, second_general_output_strap} and expected advertisement
   localparam logic [20:0] ROWS [8] = '{{5'b00111, 16'h0000},
      {5'b01000, 16'h9001}, {5'b01010, 16'h9401}, {5'b01011, 16'h9401},
      {5'b01100, 16'h9801}, {5'b01101, 16'h0020}, {5'b10000, 16'h9801},
      {5'b11111, 16'h0020}};
   logic        clk_sys = 1'b0, reset = 1'b1, col = 1'b0, dv = 1'b0;
   logic        second_general_output_strap = 1'b0, los = 1'b0, cdr = 1'b0, lnk = 1'b0;
   logic        an = 1'b0, sg = 1'b1;
   logic [1:0]  rxd = 2'b00;
   logic [15:0] pab = 16'h0000, rd, txw;
   logic        mdc, mdio_in, mdio_out, mdio_oe, rff, luf, sam;
   int          mismatches = 0, cmp_count = 0;
   // 50 MHz clock
   always #10 clk_sys = ~clk_sys;
   mdsr_mdio_master mst (.clk_sys(clk_sys), .mdc(mdc), .mdio_in(mdio_in),
      .mdio_out(mdio_out), .mdio_oe(mdio_oe));
   mdsr_regs #(.DEV_ID(DEVID)) dut (.clk_sys(clk_sys), .reset(reset),
      .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
      .strap_col(col), .strap_rx_dv(dv), .strap_rxd(rxd), .strap_second_general_output_strap(second_general_output_strap),
      .loss_of_signal_input(los), .cdr_lock_lost(cdr), .pcs_link_up(lnk),
      .autoneg_done(an), .sgmii_mode(sg), .partner_ability_reg(pab),
      .tx_config_word(txw), .remote_fault_flag(rff), .link_up_flag(luf),
      .sgmii_adv_mode(sam));
   task automatic wclk(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   // reads go without preamble, writes with it
   task automatic rdr(input logic [4:0] ra);
      mst.frame(1'b0, `MDSR_OP_READ, 5'h00, ra, 16'h0000, rd);
   endtask
   task automatic wrr(input logic [4:0] ra, input logic [15:0] wd);
      logic [15:0] v;
      mst.frame(1'b1, `MDSR_OP_WRITE, 5'h00, ra, wd, v);
   endtask
   // synchroniser needs a few clocks before the first frame
   task automatic do_reset();
      reset <= 1'b1;
      wclk(16);
      reset <= 1'b0;
      wclk(8);
   endtask
   task automatic t_straps();
      foreach (ROWS[i]) begin
         {col, dv, rxd, second_general_output_strap} <= ROWS[i][20:16];
         do_reset();
         `CHK("tx word", ROWS[i][15:0], txw)
         `CHK("layout", ROWS[i][0], sam)
         rdr(`MDSR_ADDR_ADVERT);
         `CHK("advert", ROWS[i][15:0], rd)
      end
      $display("straps test done");
   endtask
   task automatic t_ids();
      wrr(`MDSR_ADDR_ID_HIGH, 16'hffff);
      rdr(`MDSR_ADDR_ID_HIGH);
      `CHK("id high", 16'h0000, rd)
      rdr(`MDSR_ADDR_ID_LOW);
      `CHK("id low", 16'h0000, rd)
      rdr(`MDSR_ADDR_DEV_ID);
      `CHK("device id", DEVID, rd)
      rdr(5'h10);
      `CHK("unmapped", 16'h0000, rd)
      mst.frame(1'b0, `MDSR_OP_READ, 5'h07, `MDSR_ADDR_DEV_ID, 16'h0, rd);
      `CHK("other phy", 16'hffff, rd)
      $display("id test done");
   endtask
   task automatic t_status();
      for (int k = 0; k < 2; k++) begin
         an <= k[0];
         rdr(`MDSR_ADDR_STATUS);
         `CHK("fixed", 16'h0149, rd & 16'h07df)
         `CHK("an done", k[0], rd[5])
      end
      $display("status test done");
   endtask
   task automatic t_fault();
      los <= 1'b1;
      wclk(4);
      los <= 1'b0;
      wclk(10);
      `CHK("rf pin", 1'b1, rff)
      rdr(`MDSR_ADDR_STATUS);
      `CHK("rf bit", 1'b1, rd[4])
      `CHK("rf clear", 1'b0, rff)
      cdr <= 1'b1;
      rdr(`MDSR_ADDR_STATUS);
      `CHK("rf held", 1'b1, rff)
      cdr <= 1'b0;
      rdr(`MDSR_ADDR_STATUS);
      rdr(`MDSR_ADDR_STATUS);
      `CHK("rf gone", 1'b0, rd[4])
      sg <= 1'b0;
      for (int k = 1; k < 4; k++) begin
         pab <= {2'b00, k[1:0], 12'h000};
         wclk(3);
         pab <= 16'h0000;
         rdr(`MDSR_ADDR_STATUS);
         `CHK("rf word", 1'b1, rd[4])
      end
      sg <= 1'b1;
      $display("fault test done");
   endtask
   task automatic t_link();
      lnk <= 1'b1;
      wclk(4);
      `CHK("lk low", 1'b0, luf)
      rdr(`MDSR_ADDR_STATUS);
      `CHK("lk set", 1'b1, luf)
      lnk <= 1'b0;
      wclk(2);
      lnk <= 1'b1;
      wclk(2);
      rdr(`MDSR_ADDR_STATUS);
      `CHK("lk bit", 1'b0, rd[2])
      lnk <= 1'b0;
      rdr(`MDSR_ADDR_STATUS);
      `CHK("lk kept", 1'b0, luf)
      $display("link test done");
   endtask
   task automatic t_write();
      wrr(`MDSR_ADDR_ADVERT, 16'hffff);
      rdr(`MDSR_ADDR_ADVERT);
      `CHK("advert", 16'hbfff, rd)
      `CHK("tx word", 16'hbfff, txw)
      `CHK("layout", 1'b1, sam)
      wrr(`MDSR_ADDR_ADVERT, 16'h4020);
      `CHK("tx word", 16'h0020, txw)
      `CHK("layout", 1'b0, sam)
      $display("write test done");
   endtask
   task automatic end_of_test();
      $display("compares %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // main sequence
   initial begin
      do_reset();
      t_straps();
      t_ids();
      t_status();
      t_fault();
      t_link();
      t_write();
      end_of_test();
   end
   // watchdog, well beyond the expected run length
   initial begin
      wclk(60000);
      mismatches++;
      end_of_test();
   end
endmodule
`default_nettype wire
